// *** rtl/undervoltage_reset_and_interrupt.sv ***
// undervoltage reset and interrupt logic with its apb register slave
//
// Register access over APB and the placing of the registers are this design's own decisions.
`include "uvd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module undervoltage_reset_and_interrupt #(
  parameter int PRESCALE_CYCLES = `UVD_PRESCALE_CYCLES,
  parameter int FILTER_CYCLES = `UVD_FILTER_CYCLES
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`UVD_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXTERNAL_RESET_PIN_N,
  input wire logic WATCHDOG_RESET,
  input wire logic BELOW_FALL_LEVEL,
  input wire logic ABOVE_RISE_LEVEL,
  input wire logic BELOW_RESET_LEVEL,
  output logic DETECTOR_POWER_ON,
  output logic RESET_LEVEL_SELECT,
  output logic UNDERVOLT_RESET_N,
  output logic UNDERVOLT_INT_N,
  output logic EXTERNAL_IRQ_ZERO,
  output logic INTERNAL_RESET_N
);

  localparam int PW = $clog2(PRESCALE_CYCLES);
  localparam int FW = $clog2(FILTER_CYCLES + 1);
  localparam logic [PW-1:0] PRESCALE_LAST = PW'(PRESCALE_CYCLES - 1);
  localparam logic [FW-1:0] FILTER_LAST = FW'(FILTER_CYCLES - 1);
  localparam logic [15:0] CTRL_INDEX = `UVD_CTRL_INDEX;
  localparam logic [15:0] STATUS_INDEX = `UVD_STATUS_INDEX;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic pin_sync;
  logic below_fall;
  logic above_rise;
  logic below_reset;
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {EXTERNAL_RESET_PIN_N, BELOW_FALL_LEVEL, ABOVE_RISE_LEVEL, BELOW_RESET_LEVEL};
      sync_b <= sync_a;
    end
  end

  assign pin_sync = sync_b[3];
  assign below_fall = sync_b[2];
  assign above_rise = sync_b[1];
  assign below_reset = sync_b[0];
  // ****************************************************************
  // reset pin noise filter
  // ****************************************************************
  // level accepted only after it stays put for the whole filter time
  logic pin_level;
  logic [FW-1:0] filter_cnt;
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_level <= 1'b0;
      filter_cnt <= '0;
    end else if (pin_sync == pin_level) begin
      filter_cnt <= '0;
    end else if (filter_cnt == FILTER_LAST) begin
      pin_level <= pin_sync;
      filter_cnt <= '0;
    end else begin
      filter_cnt <= filter_cnt + FW'(1);
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  logic power_on;
  logic level_select;
  logic reset_enable;
  logic fall_enable;
  logic rise_enable;
  logic lv_trigger;
  logic full_clear;
  logic apb_done;
  logic wr_ctrl;
  logic wr_status;
  logic rd_status;
  logic [7:0] wbyte;
  // pin or watchdog reset clears the control bits, flags and detector state as a power-on reset does
  assign full_clear = !pin_level || WATCHDOG_RESET;
  assign apb_done = PSEL && PENABLE && PREADY;
  assign wbyte = PWDATA[7:0];
  assign wr_ctrl = apb_done && PWRITE && PADDR[`UVD_ADDR_W-1:2] == CTRL_INDEX;
  assign wr_status = apb_done && PWRITE && PADDR[`UVD_ADDR_W-1:2] == STATUS_INDEX;
  assign rd_status = apb_done && !PWRITE && PADDR[`UVD_ADDR_W-1:2] == STATUS_INDEX;

  // bits that only power-on, pin or watchdog reset may initialise
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      power_on <= 1'((`UVD_CTRL_RESET >> `UVD_CTRL_POWER_BIT) & 8'h01);
      level_select <= 1'b0;
      reset_enable <= 1'b0;
    end else if (full_clear) begin
      power_on <= 1'b0;
      level_select <= 1'b0;
      reset_enable <= 1'b0;
    end else if (wr_ctrl) begin
      power_on <= wbyte[`UVD_CTRL_POWER_BIT];
      level_select <= wbyte[`UVD_CTRL_LEVEL_BIT];
      reset_enable <= wbyte[`UVD_CTRL_RST_EN_BIT];
    end
  end

  // interrupt enables also drop on a low-voltage reset
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fall_enable <= 1'b0;
      rise_enable <= 1'b0;
    end else if (full_clear || lv_trigger) begin
      fall_enable <= 1'b0;
      rise_enable <= 1'b0;
    end else if (wr_ctrl) begin
      fall_enable <= wbyte[`UVD_CTRL_FALL_EN_BIT];
      rise_enable <= wbyte[`UVD_CTRL_RISE_EN_BIT];
    end
  end

  // ****************************************************************
  // voltage event detection
  // ****************************************************************
  // comparators are meaningless while the detector is in standby
  logic irq_function;
  logic fall_seen;
  logic rise_seen;
  logic fall_event;
  logic rise_event;
  logic rise_armed;
  assign irq_function = power_on && (fall_enable || rise_enable);
  assign fall_event = power_on && below_fall && !fall_seen;
  assign rise_event = power_on && fall_seen && above_rise && !below_reset;

  // int line tracks the fall/rise pair as a level
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fall_seen <= 1'b0;
    end else if (full_clear || lv_trigger || !power_on) begin
      fall_seen <= 1'b0;
    end else if (fall_event) begin
      fall_seen <= 1'b1;
    end else if (rise_event) begin
      fall_seen <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rise_armed <= 1'b0;
    end else if (full_clear || lv_trigger || below_reset) begin
      rise_armed <= 1'b0;
    end else if (fall_event) begin
      rise_armed <= rise_enable;
    end else if (rise_event) begin
      rise_armed <= 1'b0;
    end
  end

  assign rise_seen = rise_event && rise_armed && rise_enable;
  // ****************************************************************
  // status flags
  // ****************************************************************
  logic fall_flag;
  logic rise_flag;
  logic fall_read_one;
  logic rise_read_one;
  logic clr_fall;
  logic clr_rise;
  assign clr_fall = wr_status && !wbyte[`UVD_STAT_FALL_BIT] && fall_read_one;
  assign clr_rise = wr_status && !wbyte[`UVD_STAT_RISE_BIT] && rise_read_one;

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fall_flag <= 1'b0;
    end else if (full_clear || lv_trigger) begin
      fall_flag <= 1'b0;
    end else if (fall_event) begin
      fall_flag <= 1'b1;
    end else if (clr_fall) begin
      fall_flag <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rise_flag <= 1'b0;
    end else if (full_clear || lv_trigger) begin
      rise_flag <= 1'b0;
    end else if (rise_seen) begin
      rise_flag <= 1'b1;
    end else if (clr_rise) begin
      rise_flag <= 1'b0;
    end
  end

  // remembers that software saw the flag as one
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fall_read_one <= 1'b0;
      rise_read_one <= 1'b0;
    end else if (full_clear || lv_trigger) begin
      fall_read_one <= 1'b0;
      rise_read_one <= 1'b0;
    end else begin
      if (rd_status && PRDATA[`UVD_STAT_FALL_BIT]) begin
        fall_read_one <= 1'b1;
      end else if (clr_fall || !fall_flag) begin
        fall_read_one <= 1'b0;
      end
      if (rd_status && PRDATA[`UVD_STAT_RISE_BIT]) begin
        rise_read_one <= 1'b1;
      end else if (clr_rise || !rise_flag) begin
        rise_read_one <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // low-voltage reset and prescaler
  // ****************************************************************
  logic lv_active;
  uvd_pkg::prescale_state_e state;
  logic [PW-1:0] prescale_cnt;
  // interrupt use at the low level also forces the reset path
  assign lv_trigger = power_on && below_reset && (reset_enable || irq_function) && !lv_active;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lv_active <= 1'b0;
    end else if (full_clear) begin
      lv_active <= 1'b0;
    end else if (lv_trigger) begin
      lv_active <= 1'b1;
    end else if (!below_reset) begin
      lv_active <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= uvd_pkg::PRESCALE_HOLD;
      prescale_cnt <= '0;
    end else if (!pin_level || lv_active || lv_trigger) begin
      state <= uvd_pkg::PRESCALE_HOLD;
      prescale_cnt <= '0;
    end else begin
      case (state)
        uvd_pkg::PRESCALE_HOLD: begin
          state <= uvd_pkg::PRESCALE_COUNT;
          prescale_cnt <= '0;
        end
        uvd_pkg::PRESCALE_COUNT: begin
          if (prescale_cnt == PRESCALE_LAST) begin
            state <= uvd_pkg::PRESCALE_RUN;
          end else begin
            prescale_cnt <= prescale_cnt + PW'(1);
          end
        end
        default: begin
          state <= uvd_pkg::PRESCALE_RUN;
        end
      endcase
    end
  end

  // ****************************************************************
  // outputs toward the chip
  // ****************************************************************
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      INTERNAL_RESET_N <= 1'b0;
      UNDERVOLT_RESET_N <= 1'b1;
    end else begin
      INTERNAL_RESET_N <= state == uvd_pkg::PRESCALE_RUN && pin_level && !lv_active && !lv_trigger;
      UNDERVOLT_RESET_N <= !(lv_active || lv_trigger);
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      UNDERVOLT_INT_N <= 1'b1;
      EXTERNAL_IRQ_ZERO <= 1'b0;
    end else begin
      UNDERVOLT_INT_N <= !(fall_event || (fall_seen && !rise_event));
      EXTERNAL_IRQ_ZERO <= (fall_event && fall_enable) || rise_seen;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DETECTOR_POWER_ON <= 1'b0;
      RESET_LEVEL_SELECT <= 1'b0;
    end else begin
      DETECTOR_POWER_ON <= power_on;
      RESET_LEVEL_SELECT <= level_select;
    end
  end

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // one wait state so read data and pready both come from flops
  logic [7:0] ctrl_view;
  logic [7:0] status_view;
  assign ctrl_view = `UVD_CTRL_RSVD_ONES | {power_on, 3'h0, level_select, reset_enable, fall_enable, rise_enable};
  assign status_view = `UVD_STAT_RSVD_ONES | {6'h00, fall_flag, rise_flag};

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (PSEL && PENABLE && !PREADY) begin
      PREADY <= 1'b1;
      if (PADDR[`UVD_ADDR_W-1:2] == CTRL_INDEX) begin
        PRDATA <= {24'h000000, ctrl_view};
        PSLVERR <= 1'b0;
      end else if (PADDR[`UVD_ADDR_W-1:2] == STATUS_INDEX) begin
        PRDATA <= {24'h000000, status_view};
        PSLVERR <= 1'b0;
      end else begin
        PRDATA <= 32'h00000000;
        PSLVERR <= 1'b1;
      end
    end else begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** rtl/uvd_cfg.svh ***
// constants for the undervoltage reset and interrupt block
`ifndef UVD_CFG_SVH
`define UVD_CFG_SVH

// register indices; byte address is four times the index
`define UVD_CTRL_INDEX 16'hf730
`define UVD_STATUS_INDEX 16'hf731
`define UVD_ADDR_W 18

// control register fields
`define UVD_CTRL_POWER_BIT 7
`define UVD_CTRL_LEVEL_BIT 3
`define UVD_CTRL_RST_EN_BIT 2
`define UVD_CTRL_FALL_EN_BIT 1
`define UVD_CTRL_RISE_EN_BIT 0
`define UVD_CTRL_RSVD_ONES 8'h70

// status register fields
`define UVD_STAT_FALL_BIT 1
`define UVD_STAT_RISE_BIT 0
`define UVD_STAT_RSVD_ONES 8'hfc

// reset values
`define UVD_CTRL_RESET 8'h00
`define UVD_STAT_RESET 8'h00

// timing
`define UVD_CLK_PERIOD_NS 10
`define UVD_FILTER_NS 100
`define UVD_FILTER_CYCLES ((`UVD_FILTER_NS + `UVD_CLK_PERIOD_NS - 1) / `UVD_CLK_PERIOD_NS)
`define UVD_PRESCALE_CYCLES 131072
`define UVD_SETTLE_US 50
`define UVD_SETTLE_CYCLES ((`UVD_SETTLE_US * 1000) / `UVD_CLK_PERIOD_NS)

`endif

// *** rtl/uvd_pkg.sv ***
// types for the undervoltage reset and interrupt block
package uvd_pkg;

  typedef enum logic [1:0] {
    PRESCALE_HOLD = 2'b00,
    PRESCALE_COUNT = 2'b01,
    PRESCALE_RUN = 2'b10
  } prescale_state_e;

endpackage

// *** tb/uvd_monitor.sv ***
// checker of the undervoltage reset and interrupt block ports
`timescale 1ns/1ps
`default_nettype none
`include "uvd_cfg.svh"
module uvd_monitor #(
  parameter int PRESCALE_CYCLES = 16,
  parameter int FILTER_CYCLES = 3
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic PWRITE,
  input wire logic [`UVD_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic EXTERNAL_RESET_PIN_N,
  input wire logic BELOW_FALL_LEVEL,
  input wire logic BELOW_RESET_LEVEL,
  input wire logic DETECTOR_POWER_ON,
  input wire logic UNDERVOLT_RESET_N,
  input wire logic UNDERVOLT_INT_N,
  input wire logic EXTERNAL_IRQ_ZERO,
  input wire logic INTERNAL_RESET_N
);
  localparam int RLO = PRESCALE_CYCLES;
  localparam int RHI = PRESCALE_CYCLES + 4;
  localparam int PLO = PRESCALE_CYCLES + FILTER_CYCLES;
  localparam int PHI = PRESCALE_CYCLES + FILTER_CYCLES + 8;
  logic rd_ok;
  assign rd_ok = PREADY && !PWRITE && !PSLVERR;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  AST_STATUS_ONES: assert property (rd_ok && PADDR[17:2] == `UVD_STATUS_INDEX |-> PRDATA[7:2] == 6'h3f)
    else $error("status reserved bits not one");
  AST_CTRL_LAYOUT: assert property (rd_ok && PADDR[17:2] == `UVD_CTRL_INDEX |->
    PRDATA[6:4] == 3'h7 && PRDATA[7] == DETECTOR_POWER_ON) else $error("control layout wrong");
  AST_FALL_INT: assert property ($fell(UNDERVOLT_INT_N) |-> $past(BELOW_FALL_LEVEL, 2))
    else $error("interrupt low without fall");
  AST_SYNC_DELAY: assert property ($rose(BELOW_FALL_LEVEL) && UNDERVOLT_INT_N |=> UNDERVOLT_INT_N)
    else $error("fall seen without synchroniser");
  AST_IRQ_CAUSE: assert property (EXTERNAL_IRQ_ZERO |-> $changed(UNDERVOLT_INT_N) ##1 !EXTERNAL_IRQ_ZERO)
    else $error("irq without interrupt edge");
  AST_RESET_LOW: assert property ($fell(UNDERVOLT_RESET_N) |-> $past(BELOW_RESET_LEVEL, 2) && !INTERNAL_RESET_N)
    else $error("undervolt reset wrong");
  AST_RECOVER: assert property ($rose(UNDERVOLT_RESET_N) |-> ##[RLO:RHI] $rose(INTERNAL_RESET_N))
    else $error("recovery count wrong");
  AST_POWERON: assert property ($rose(EXTERNAL_RESET_PIN_N) && !INTERNAL_RESET_N |-> ##[PLO:PHI] INTERNAL_RESET_N)
    else $error("pin release count wrong");
  AST_FILTER: assert property ($fell(EXTERNAL_RESET_PIN_N) && INTERNAL_RESET_N ##1 EXTERNAL_RESET_PIN_N
    |-> INTERNAL_RESET_N [*6]) else $error("short pin pulse reset chip");
  AST_STANDBY: assert property (!DETECTOR_POWER_ON |-> UNDERVOLT_RESET_N && !EXTERNAL_IRQ_ZERO)
    else $error("detector active in standby");
  cover property ($rose(INTERNAL_RESET_N));
  cover property (EXTERNAL_IRQ_ZERO && UNDERVOLT_INT_N);
  cover property ($fell(UNDERVOLT_RESET_N));
endmodule
bind undervoltage_reset_and_interrupt uvd_monitor #(
  .PRESCALE_CYCLES(PRESCALE_CYCLES), .FILTER_CYCLES(FILTER_CYCLES)
) i_uvd_monitor (.MCLK, .ARST_N, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .EXTERNAL_RESET_PIN_N,
  .BELOW_FALL_LEVEL, .BELOW_RESET_LEVEL, .DETECTOR_POWER_ON, .UNDERVOLT_RESET_N, .UNDERVOLT_INT_N,
  .EXTERNAL_IRQ_ZERO, .INTERNAL_RESET_N);
`default_nettype wire

// *** tb/uvd_analog_model.sv ***
// supply comparators seen by the block, driven from a millivolt value
`timescale 1ns/1ps
`default_nettype none
module uvd_analog_model (
  input wire logic [15:0] supply_mv,
  input wire logic level_select,
  output logic below_fall,
  output logic above_rise,
  output logic below_reset
);
  // 3.7 V and 4.0 V leave a band where neither comparator fires
  always_comb begin
    below_fall = supply_mv < 16'he74;
    above_rise = supply_mv > 16'hfa0;
    below_reset = supply_mv < (level_select ? 16'he10 : 16'h8fc);
  end
endmodule
`default_nettype wire

// *** tb/undervoltage_reset_and_interrupt_test.sv ***
// self-checking bench of the undervoltage reset and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "uvd_cfg.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module undervoltage_reset_and_interrupt_test;
  localparam int P = 16;
  localparam logic [15:0] CTRL = `UVD_CTRL_INDEX;
  localparam logic [15:0] STAT = `UVD_STATUS_INDEX;
  logic mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pin_n = 0, wdog = 0, err;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdata, seed = 32'h17032;
  logic [15:0] supply = 16'h1388;
  logic pready, pslverr, bfall, arise, breset, pwr, lsel, uv_rst_n, uv_int_n, irq, int_rst_n;
  int n, failures = 0, n_compared = 0;
  undervoltage_reset_and_interrupt #(.PRESCALE_CYCLES(P), .FILTER_CYCLES(3)) i_undervoltage_reset_and_interrupt (
    .MCLK(mclk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EXTERNAL_RESET_PIN_N(pin_n),
    .WATCHDOG_RESET(wdog), .BELOW_FALL_LEVEL(bfall), .ABOVE_RISE_LEVEL(arise), .BELOW_RESET_LEVEL(breset),
    .DETECTOR_POWER_ON(pwr), .RESET_LEVEL_SELECT(lsel), .UNDERVOLT_RESET_N(uv_rst_n),
    .UNDERVOLT_INT_N(uv_int_n), .EXTERNAL_IRQ_ZERO(irq), .INTERNAL_RESET_N(int_rst_n));
  uvd_analog_model i_uvd_analog_model (.supply_mv(supply), .level_select(lsel), .below_fall(bfall),
    .above_rise(arise), .below_reset(breset));
  always #5 mclk = ~mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_ctrl(input logic [7:0] c);
    return {24'h0, c | 8'h70};
  endfunction
  function automatic logic [31:0] exp_stat(input logic [1:0] f);
    return {24'h0, 6'h3f, f};
  endfunction
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) failures++;
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_irq();
    for (n = 0; n < 40 && irq !== 1'b1; n++) @(posedge mclk);
  endtask
  task automatic wait_up();
    for (n = 0; n < 200 && int_rst_n !== 1'b1; n++) @(posedge mclk);
  endtask
  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    pin_n <= 1'b1;
    wait_up();
    `CHK("por", 1'b1, int_rst_n === 1'b1 && n >= P)
    apb(0, CTRL, 0); `CHK("ctrl reset", exp_ctrl(8'h00), rdata)
    apb(0, 16'h0123, 0); `CHK("unmapped", 33'h100000000, {err, rdata})
    // detector stays unpowered, so supply swings must leave no trace
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      supply <= seed[31] ? 16'hdac : 16'h1388;
      apb(1, STAT, seed[7:0]);
      apb(0, STAT, 0); `CHK("stat", exp_stat(2'b00), rdata)
      apb(1, CTRL, seed[15:8] & 8'h08);
      apb(0, CTRL, 0); `CHK("ctrl", exp_ctrl(seed[15:8] & 8'h08), rdata)
    end
    `CHK("standby", 1'b1, uv_int_n)
    supply <= 16'h1388;
    apb(1, CTRL, 8'h80);
    repeat (`UVD_SETTLE_CYCLES) @(posedge mclk);
    apb(1, STAT, 8'h00);
    apb(1, CTRL, 8'h83);
    supply <= 16'hdac;
    wait_irq();
    `CHK("fall", 2'b10, {irq, uv_int_n})
    apb(1, STAT, 8'h00);
    apb(0, STAT, 0); `CHK("unread kept", exp_stat(2'b10), rdata)
    apb(1, STAT, 8'h00);
    apb(0, STAT, 0); `CHK("cleared", exp_stat(2'b00), rdata)
    supply <= 16'h1004;
    wait_irq();
    `CHK("rise", 2'b11, {irq, uv_int_n})
    apb(0, STAT, 0); `CHK("rise flag", exp_stat(2'b01), rdata)
    apb(1, STAT, 8'h00);
    apb(1, CTRL, 8'h82);
    supply <= 16'hdac;
    wait_irq();
    supply <= 16'h1004;
    repeat (10) @(posedge mclk);
    `CHK("int back", 1'b1, uv_int_n)
    apb(0, STAT, 0); `CHK("rise unarmed", exp_stat(2'b10), rdata)
    apb(1, CTRL, 8'h80);
    apb(1, CTRL, 8'h8c);
    supply <= 16'hdac;
    for (n = 0; n < 40 && uv_rst_n !== 1'b0; n++) @(posedge mclk);
    `CHK("lvd reset", 2'b00, {uv_rst_n, int_rst_n})
    supply <= 16'h1388;
    wait_up();
    `CHK("recover", 1'b1, int_rst_n === 1'b1 && n >= P)
    apb(0, CTRL, 0); `CHK("kept", exp_ctrl(8'h8c), rdata)
    `CHK("kept outs", 2'b11, {pwr, lsel})
    apb(1, CTRL, 8'h88);
    pin_n <= 1'b0;
    @(posedge mclk);
    pin_n <= 1'b1;
    repeat (10) @(posedge mclk);
    `CHK("short pulse", 1'b1, int_rst_n)
    pin_n <= 1'b0;
    repeat (10) @(posedge mclk);
    pin_n <= 1'b1;
    wait_up();
    `CHK("pin reset", 1'b1, int_rst_n === 1'b1 && n >= P)
    apb(0, CTRL, 0); `CHK("pin clears", exp_ctrl(8'h00), rdata)
    apb(1, CTRL, 8'h88);
    wdog <= 1'b1;
    repeat (2) @(posedge mclk);
    wdog <= 1'b0;
    apb(0, CTRL, 0); `CHK("wdog clears", exp_ctrl(8'h00), rdata)
    final_report();
  end
endmodule
`default_nettype wire
